// [include/timer_pwm_regs.vh]
// Register map and constants of the PWM and watchdog timer block
// Summary of operation
// - Mode code 0111 runs PWM, pin output.
// - Enable clears counter; first tick loads reload.
// - Compare match toggles pin, flags, captures count.
// - Overflow toggles pin, flags; optional reload.
// - PWM pin starts at polarity, then alternates.
// - Period is FFFFFF minus reload plus one.
// - Duty set by compare against reload.
// - Mode code 1001 runs watchdog pulse.
// - Watchdog match flags; reload only if enabled.
// - Watchdog pulse: one-tick pulse of polarity.
// - Watchdog-mode reload write while enabled reloads counter.
// - Watchdog-mode pin held 2.5 clocks after reset assert.
// - Mode code 1010 runs watchdog toggle.
// - Toggle mode overflow inverts pin, flags.
// - Wait state leaves timer running.
// - Stop state gates clocks, releases pin.
// - DMA trigger on every timer event.
`ifndef TIMER_PWM_REGS_VH
`define TIMER_PWM_REGS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CONTROL_STATUS 12'h000
`define OFS_RELOAD 12'h004
`define OFS_COMPARE 12'h008
`define OFS_READBACK 12'h00C
`define OFS_COUNT 12'h010
// ----------------------------------------
// control_status fields
// ----------------------------------------
`define CS_EN 0
`define CS_CIE 2
`define CS_OIE 3
`define CS_MODE_LO 4
`define CS_MODE_HI 7
`define CS_POL 8
`define CS_RELM 9
`define CS_PRE 10
`define CS_COF 20
`define CS_OF 21
`define CS_RESET 32'h0000_0000
// ----------------------------------------
// Modes and timing
// ----------------------------------------
`define MODE_PWM 4'h7
`define MODE_WDP 4'h9
`define MODE_WDT 4'hA
`define CNT_MAX 24'hFF_FFFF
`define HOLD_HALF_CLKS 3'h5
`endif

// [design/tick_gen.v]
// Timer clock enable generator: internal clock over two or prescaler tick
`timescale 1ns/1ps
`default_nettype none
module tick_gen (
	input wire core_clk,
	input wire rst_n,
	input wire run,
	input wire use_prescaler,
	input wire prescaler_tick,
	output wire tick
);
	reg div_r;
	// Divider restarts with each enable so the first tick is deterministic
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 1'b0;
		end else if (!run) begin
			div_r <= 1'b0;
		end else begin
			div_r <= ~div_r;
		end
	end
	assign tick = run & (use_prescaler ? prescaler_tick : div_r);
endmodule
`default_nettype wire

// [design/pin_hold.v]
// Holds the pin value and direction for 2.5 clocks after reset asserts
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_regs.vh"
module pin_hold (
	input wire core_clk,
	input wire rst_n,
	input wire hold_mode,
	input wire pin_in,
	input wire oe_in,
	output wire pin_out,
	output wire pin_oe
);
	reg [2:0] half_r;
	reg pin_r;
	reg oe_r;
	reg armed_r;
	// Half-cycle counter runs on both edges while reset is low
	always @(posedge core_clk or negedge core_clk) begin
		if (rst_n) begin
			half_r <= 3'h0;
		end else if (half_r != `HOLD_HALF_CLKS) begin
			half_r <= half_r + 3'h1;
		end
	end
	// Last functional values captured while out of reset
	always @(posedge core_clk) begin
		if (rst_n) begin
			pin_r <= pin_in;
			oe_r <= oe_in;
			armed_r <= hold_mode;
		end
	end
	// Hold keeps a watchdog reset pulse valid while the reset spreads
	assign pin_out = rst_n ? pin_in : (armed_r && half_r != `HOLD_HALF_CLKS) ? pin_r : 1'b0;
	assign pin_oe = rst_n ? oe_in : (armed_r && half_r != `HOLD_HALF_CLKS) ? oe_r : 1'b0;
endmodule
`default_nettype wire

// [design/timer_pwm_wdog.v]
// PWM and watchdog timer with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_regs.vh"
module timer_pwm_wdog (
	input wire core_clk,
	input wire rst_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire prescaler_tick,
	input wire stop_state,
	output wire timer_pin_out,
	output wire timer_pin_oe,
	output wire compare_irq,
	output wire overflow_irq,
	output reg dma_trigger
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg count_enable_r;
	reg compare_irq_en_r;
	reg overflow_irq_en_r;
	reg [3:0] mode_select_r;
	reg polarity_select_r;
	reg reload_on_match_r;
	reg use_prescaler_r;
	reg compare_flag_r;
	reg overflow_flag_r;
	reg [23:0] reload_value_r;
	reg [23:0] compare_value_r;
	reg [23:0] count_readback_r;
	reg [23:0] counter_r;
	reg loaded_r;
	reg reload_pend_r;
	reg pin_r;
	reg pulse_r;
	reg dph_wr_r;
	reg dph_rd_r;
	reg [11:0] dph_addr_r;
	wire tick;
	wire is_pwm;
	wire is_wdp;
	wire is_wdt;
	wire out_mode;
	wire run;
	wire match;
	wire wrap;
	wire ev_cmp;
	wire ev_ovf;
	wire reload_wr;
	wire cs_wr;
	wire [23:0] cnt_inc;
	wire pin_val;
	wire [31:0] cs_view;
	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	assign is_pwm = (mode_select_r == `MODE_PWM);
	assign is_wdp = (mode_select_r == `MODE_WDP);
	assign is_wdt = (mode_select_r == `MODE_WDT);
	assign out_mode = is_pwm | is_wdp | is_wdt;
	// Stop gates the timer clock entirely; wait needs no special case
	assign run = count_enable_r & ~stop_state;
	tick_gen u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(run),
		.use_prescaler(use_prescaler_r),
		.prescaler_tick(prescaler_tick),
		.tick(tick)
	);
	// ----------------------------------------
	// AHB-Lite slave: zero wait states, always OKAY
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Address phase captured for the following data phase
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dph_wr_r <= 1'b0;
			dph_rd_r <= 1'b0;
			dph_addr_r <= 12'h000;
		end else if (hready) begin
			dph_wr_r <= hsel & htrans[1] & hwrite;
			dph_rd_r <= hsel & htrans[1] & ~hwrite;
			dph_addr_r <= haddr[11:0];
		end
	end
	assign cs_wr = dph_wr_r && dph_addr_r == `OFS_CONTROL_STATUS;
	assign reload_wr = dph_wr_r && dph_addr_r == `OFS_RELOAD;
	assign cs_view = {10'h000, overflow_flag_r, compare_flag_r, 9'h000, use_prescaler_r,
		reload_on_match_r, polarity_select_r, mode_select_r, overflow_irq_en_r,
		compare_irq_en_r, 1'b0, count_enable_r};
	// Read data registered at the address phase so it stands in the data phase
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[11:0])
				`OFS_CONTROL_STATUS: hrdata <= cs_view;
				`OFS_RELOAD: hrdata <= {8'h00, reload_value_r};
				`OFS_COMPARE: hrdata <= {8'h00, compare_value_r};
				`OFS_READBACK: hrdata <= {8'h00, count_readback_r};
				`OFS_COUNT: hrdata <= {8'h00, counter_r};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
	// ----------------------------------------
	// Counter
	// ----------------------------------------
	assign cnt_inc = counter_r + 24'h00_0001;
	assign match = tick && loaded_r && !reload_pend_r && counter_r == compare_value_r;
	// Wrap from all ones to zero is the overflow
	assign wrap = tick && loaded_r && !reload_pend_r && counter_r == `CNT_MAX;
	assign ev_cmp = match & out_mode;
	assign ev_ovf = wrap;
	// Counter cleared on enable, loaded on first tick, then incremented
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_r <= 24'h00_0000;
			loaded_r <= 1'b0;
			reload_pend_r <= 1'b0;
		end else if (!count_enable_r) begin
			counter_r <= 24'h00_0000;
			loaded_r <= 1'b0;
			reload_pend_r <= 1'b0;
		end else if (reload_wr && (is_wdp || is_wdt)) begin
			counter_r <= hwdata[23:0];
			loaded_r <= 1'b1;
			reload_pend_r <= 1'b0;
		end else if (tick) begin
			if (!loaded_r || reload_pend_r) begin
				counter_r <= reload_value_r;
				loaded_r <= 1'b1;
				reload_pend_r <= 1'b0;
			end else if (is_pwm && wrap && reload_on_match_r) begin
				// PWM reload rides on the overflow tick so the period stays exact
				counter_r <= reload_value_r;
			end else begin
				counter_r <= cnt_inc;
				// Watchdogs with reload-on-match set reload on the tick after a match
				if ((is_wdp || is_wdt) && match) begin
					reload_pend_r <= reload_on_match_r;
				end
			end
		end
	end
	// A PWM-mode match captures the count for readback
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_readback_r <= 24'h00_0000;
		end else if (ev_cmp && is_pwm) begin
			count_readback_r <= counter_r;
		end
	end
	// ----------------------------------------
	// Pin output
	// ----------------------------------------
	// Start at polarity; PWM toggles on match and wrap, toggle mode on wrap
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_r <= 1'b0;
			pulse_r <= 1'b0;
		end else if (!count_enable_r) begin
			// The enabling write carries the polarity, so take it from the bus
			pin_r <= cs_wr ? hwdata[`CS_POL] : polarity_select_r;
			pulse_r <= 1'b0;
		end else begin
			if (is_pwm && (ev_cmp ^ ev_ovf)) begin
				pin_r <= ~pin_r;
			end else if (is_wdt && ev_ovf) begin
				pin_r <= ~pin_r;
			end
			// Pulse lasts from the overflow tick until the next tick
			if (is_wdp && ev_ovf) begin
				pulse_r <= 1'b1;
			end else if (tick) begin
				pulse_r <= 1'b0;
			end
		end
	end
	// Idle level of a watchdog pulse is the inverse of its polarity
	assign pin_val = is_wdp ? (pulse_r ? polarity_select_r : ~polarity_select_r) : pin_r;
	pin_hold u_hold (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hold_mode(is_wdp | is_wdt),
		.pin_in(pin_val),
		.oe_in(out_mode & count_enable_r & ~stop_state),
		.pin_out(timer_pin_out),
		.pin_oe(timer_pin_oe)
	);
	// ----------------------------------------
	// Control, flags, DMA trigger
	// ----------------------------------------
	// Flags are write-one-to-clear; a new event beats a clear in the same cycle
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_enable_r <= 1'b0;
			compare_irq_en_r <= 1'b0;
			overflow_irq_en_r <= 1'b0;
			mode_select_r <= 4'h0;
			polarity_select_r <= 1'b0;
			reload_on_match_r <= 1'b0;
			use_prescaler_r <= 1'b0;
			compare_flag_r <= 1'b0;
			overflow_flag_r <= 1'b0;
			reload_value_r <= 24'h00_0000;
			compare_value_r <= 24'h00_0000;
			dma_trigger <= 1'b0;
		end else begin
			if (cs_wr) begin
				count_enable_r <= hwdata[`CS_EN];
				compare_irq_en_r <= hwdata[`CS_CIE];
				overflow_irq_en_r <= hwdata[`CS_OIE];
				mode_select_r <= hwdata[`CS_MODE_HI:`CS_MODE_LO];
				polarity_select_r <= hwdata[`CS_POL];
				reload_on_match_r <= hwdata[`CS_RELM];
				use_prescaler_r <= hwdata[`CS_PRE];
			end
			if (reload_wr) begin
				reload_value_r <= hwdata[23:0];
			end
			if (dph_wr_r && dph_addr_r == `OFS_COMPARE) begin
				compare_value_r <= hwdata[23:0];
			end
			compare_flag_r <= ev_cmp | (compare_flag_r & ~(cs_wr & hwdata[`CS_COF]));
			overflow_flag_r <= ev_ovf | (overflow_flag_r & ~(cs_wr & hwdata[`CS_OF]));
			dma_trigger <= ev_cmp | ev_ovf;
		end
	end
	// Interrupt requests are levels until the flag is cleared; they also wake from wait
	assign compare_irq = compare_flag_r & compare_irq_en_r;
	assign overflow_irq = overflow_flag_r & overflow_irq_en_r;
endmodule
`default_nettype wire

// [test/timer_pwm_checker_assertions.sv]
// Port checker of the PWM and watchdog timer
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic stop_state,
	input wire logic timer_pin_oe,
	input wire logic compare_irq,
	input wire logic overflow_irq,
	input wire logic dma_trigger
);
	// ----
	// Assertions
	// ----
	// Request decode; a flag can only drop through a bus write
	wire logic req = hsel && hready && htrans[1];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	bus_ready_a: assert property (hreadyout) else $error("wait state seen");
	bus_okay_a: assert property (!hresp) else $error("error response seen");
	rdata_hold_a: assert property (!$past(req && !hwrite) |-> $stable(hrdata))
		else $error("read data moved without a read");
	reset_quiet_a: assert property ($rose(rst_n) |-> !compare_irq && !overflow_irq && !dma_trigger)
		else $error("flags set right after reset");
	cmp_clear_a: assert property ($fell(compare_irq) |-> $past(req && hwrite, 2))
		else $error("compare flag dropped without a write");
	ovf_clear_a: assert property ($fell(overflow_irq) |-> $past(req && hwrite, 2))
		else $error("overflow flag dropped without a write");
	dma_pulse_a: assert property (dma_trigger |=> !dma_trigger)
		else $error("trigger longer than one cycle");
	stop_oe_a: assert property (stop_state [*2] |-> !timer_pin_oe)
		else $error("pin driven in stop");
	stop_quiet_a: assert property (stop_state [*3] |-> !dma_trigger)
		else $error("timer event in stop");
	cover property ($rose(compare_irq));
	cover property ($rose(overflow_irq));
	cover property (stop_state ##1 !timer_pin_oe);
endmodule
bind timer_pwm_wdog timer_pwm_checker chk (.core_clk, .rst_n, .hsel, .htrans, .hwrite, .hready,
	.hrdata, .hreadyout, .hresp, .stop_state, .timer_pin_oe, .compare_irq, .overflow_irq,
	.dma_trigger);
`default_nettype wire

// [test/pin_watch.sv]
// Model of the circuit listening on the timer pin
`timescale 1ns/1ps
`default_nettype none
module pin_watch (
	input wire logic core_clk,
	input wire logic pin,
	input wire logic oe,
	output logic [15:0] last_len,
	output logic [15:0] prev_len
);
	// ----
	// Interval meter
	// ----
	logic seen_r;
	logic [15:0] cnt_r;
	wire logic level = oe ? pin : 1'b0; // Pull-down holds a released line low
	initial begin
		seen_r = 1'b0;
		cnt_r = 16'h0000;
		last_len = 16'h0000;
		prev_len = 16'h0000;
	end
	// Lengths of the two latest levels, in clocks
	always @(posedge core_clk) begin
		if (level !== seen_r) begin
			prev_len <= last_len;
			last_len <= cnt_r;
			cnt_r <= 16'h0001;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
		seen_r <= level;
	end
endmodule
`default_nettype wire

// [test/tb_timer_pwm_watchdog_modes.sv]
// Self-checking bench of the PWM and watchdog timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_pwm_regs.vh"
module tb_timer_pwm_watchdog_modes;
	// ----
	// Harness
	// ----
	logic core_clk, rst_n, hsel, hwrite, stop_state, prescaler_tick;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, rd, keep;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, timer_pin_out, timer_pin_oe, compare_irq, overflow_irq, dma;
	wire logic [15:0] last_len, prev_len;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	timer_pwm_wdog dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .prescaler_tick, .stop_state,
		.timer_pin_out, .timer_pin_oe, .compare_irq, .overflow_irq, .dma_trigger(dma));
	pin_watch mon (.core_clk, .pin(timer_pin_out), .oe(timer_pin_oe), .last_len, .prev_len);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard; a normal run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			test_done;
		end
	end
	task test_done;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Single AHB-Lite word transfer; read data lands in rd
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rdck(input string nm, input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		check(nm, rd, exp);
	endtask
	task wait_irq(input logic ovf);
		for (int i = 0; i < 200 && (ovf ? overflow_irq : compare_irq) !== 1'b1; i++)
			@(posedge core_clk);
		tick(1);
	endtask
	// Enable with both interrupt enables set (bits 0, 2, 3); only defined modes
	// No DMA consumer here takes longer than a cycle, so no trigger queues
	function automatic logic [31:0] ctl(input logic [3:0] m, input logic pol, input logic relm);
		ctl = 32'h0000_000D | (m << `CS_MODE_LO) | (pol << `CS_POL) | (relm << `CS_RELM);
	endfunction
	// ----
	// Scenarios
	// ----
	task t_reset;
		rdck("control_status", `OFS_CONTROL_STATUS, `CS_RESET);
		wr(32'h0000_0020, 32'hFFFF_FFFF);
		rdck("unmapped", 32'h0000_0020, 32'h0000_0000);
	endtask
	task t_pwm;
		wr(`OFS_RELOAD, 32'h00FF_FFF0);
		wr(`OFS_COMPARE, 32'h00FF_FFF8); // Kept above reload
		wr(`OFS_CONTROL_STATUS, ctl(`MODE_PWM, 1'b1, 1'b1));
		tick(1);
		check("pwm start", {timer_pin_oe, timer_pin_out}, 2'b11);
		wait_irq(1'b0);
		check("pwm match pin", timer_pin_out, 1'b0);
		rdck("readback", `OFS_READBACK, 32'h00FF_FFF8);
		wait_irq(1'b1);
		check("pwm wrap pin", timer_pin_out, 1'b1);
		for (int i = 0; i < 100 && timer_pin_out !== 1'b0; i++)
			@(posedge core_clk);
		tick(1);
		check("low time", prev_len, 16'd14);
		check("high time", last_len, 16'd18);
		wr(`OFS_CONTROL_STATUS, 32'h0030_0000);
		tick(2);
		check("flags cleared", {compare_irq, overflow_irq}, 2'b00);
	endtask
	task t_wdp;
		wr(`OFS_RELOAD, 32'h00FF_FFF8);
		wr(`OFS_COMPARE, 32'h00FF_FFFA);
		wr(`OFS_CONTROL_STATUS, ctl(`MODE_WDP, 1'b1, 1'b0));
		tick(1);
		check("pulse idle", {timer_pin_oe, timer_pin_out}, 2'b10);
		wait_irq(1'b1);
		tick(4);
		check("pulse width", last_len, 16'd2);
		check("wd match", compare_irq, 1'b1);
		wr(`OFS_RELOAD, 32'h00FF_FF00);
		xfer(1'b0, `OFS_COUNT, 32'h0000_0000);
		check("reloaded", rd & 32'hFFFF_FFFE, 32'h00FF_FF00);
		wr(`OFS_CONTROL_STATUS, 32'h0030_0000);
	endtask
	task t_wdt;
		wr(`OFS_RELOAD, 32'h00FF_FFF8);
		wr(`OFS_CONTROL_STATUS, ctl(`MODE_WDT, 1'b0, 1'b0));
		tick(1);
		check("toggle start", {timer_pin_oe, timer_pin_out}, 2'b10);
		wait_irq(1'b1);
		check("toggle wrap", timer_pin_out, 1'b1);
		stop_state <= 1'b1; // Runs into stop on purpose to see the freeze
		tick(3);
		check("stop oe", timer_pin_oe, 1'b0);
		xfer(1'b0, `OFS_COUNT, 32'h0000_0000);
		keep = rd;
		tick(6);
		rdck("frozen", `OFS_COUNT, keep);
		stop_state <= 1'b0;
		tick(2);
		rst_n <= 1'b0;
		tick(2);
		#1 check("reset hold", {timer_pin_oe, timer_pin_out}, 2'b11);
		tick(2);
		#1 check("reset release", {timer_pin_oe, timer_pin_out}, 2'b00);
		@(posedge core_clk);
		rst_n <= 1'b1;
		tick(2);
	endtask
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		stop_state = 1'b0;
		prescaler_tick = 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(1);
		t_reset;
		t_pwm;
		t_wdp;
		t_wdt;
		test_done;
	end
endmodule
`default_nettype wire
